// file: hw/tcp_timer.sv
// Summary of operation
// - five channels, eight output behaviours each
// - continuous mode wraps 0FFFFh to zero
// - continuous mode: channel 0 ordinary compare
// - compare match applies action, raises interrupt
// - up mode clears at channel 0 value
// - channel 0 sets period for others
// - up-down turns at channel 0, zero
// - up-down matches twice per cycle
// - count clock up to core clock rate
`timescale 1ns/100ps
`default_nettype none

module tcp_timer
  import tcp_pkg::*;
#(
  parameter int unsigned N_CH = NUM_CH
)
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_count_pin,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_irq,
  output logic [N_CH-1:0] o_pwm
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by reads and writes
  function automatic logic ch_hit(input logic [7:0] adr);
    logic [7:0] off;
    off = adr - OFS_CH_BASE;
    ch_hit = (adr >= OFS_CH_BASE)
      && (int'(off[7:CH_STEP_SH]) < int'(N_CH));
  endfunction : ch_hit

  function automatic int ch_idx(input logic [7:0] adr);
    logic [7:0] off;
    off = adr - OFS_CH_BASE;
    ch_idx = int'(off[7:CH_STEP_SH]);
  endfunction : ch_idx

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    merge16 = old;
    if (sel[0])
      merge16[7:0] = wdat[7:0];
    if (sel[1])
      merge16[15:8] = wdat[15:8];
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // register group
  tcp_mode_t mode, next_mode;
  logic src, next_src;
  logic [1:0] div, next_div;
  tcp_cfg_t cfg [N_CH];
  tcp_cfg_t next_cfg [N_CH];
  logic [15:0] ccr [N_CH];
  logic [15:0] next_ccr [N_CH];
  logic [N_CH-1:0] en, next_en;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic hit, wr;
  logic cnt_wr, cnt_clr;
  logic [N_CH-1:0] clr_mask;
  logic [N_CH-1:0] stat, next_stat;

  assign hit = i_wb_cyc && i_wb_stb && !ack;
  assign wr = hit && i_wb_we;
  assign cnt_wr = wr && i_wb_adr[7:2] == OFS_COUNT[7:2];
  assign cnt_clr = wr && i_wb_adr[7:2] == OFS_CTRL[7:2] && i_wb_sel[0]
    && i_wb_dat[CTRL_CLR_BIT];
  assign o_wb_ack = ack;
  assign o_wb_dat = rdat;

  logic [15:0] cnt;

  always_comb
  begin
    next_mode = mode;
    next_src = src;
    next_div = div;
    next_en = en;
    next_cfg = cfg;
    next_ccr = ccr;
    clr_mask = '0;
    next_ack = hit;
    next_rdat = 32'h0000_0000;
    if (wr)
    begin
      case ({i_wb_adr[7:2], 2'b00})
        OFS_CTRL:
        begin
          if (i_wb_sel[0])
          begin
            next_mode = tcp_mode_t'(i_wb_dat[CTRL_MODE_LSB +: 2]);
            next_src = i_wb_dat[CTRL_SRC_BIT];
            next_div = i_wb_dat[CTRL_DIV_LSB +: 2];
          end
        end
        OFS_CLR:
          if (i_wb_sel[0])
            clr_mask = i_wb_dat[N_CH-1:0];
        OFS_EN:
          if (i_wb_sel[0])
            next_en = i_wb_dat[N_CH-1:0];
        default:
        begin
          if (ch_hit(i_wb_adr) && i_wb_adr[CH_CCR_BIT])
            next_ccr[ch_idx(i_wb_adr)] =
              merge16(ccr[ch_idx(i_wb_adr)], i_wb_dat, i_wb_sel);
          else if (ch_hit(i_wb_adr) && i_wb_sel[0])
            next_cfg[ch_idx(i_wb_adr)] = tcp_cfg_t'(i_wb_dat[CFG_W-1:0]);
        end
      endcase
    end
    else if (hit)
    begin
      // unmapped words and write-only clear read as zero
      case ({i_wb_adr[7:2], 2'b00})
        OFS_CTRL:
        begin
          next_rdat[CTRL_MODE_LSB +: 2] = mode;
          next_rdat[CTRL_SRC_BIT] = src;
          next_rdat[CTRL_DIV_LSB +: 2] = div;
        end
        OFS_COUNT: next_rdat[15:0] = cnt;
        OFS_STAT: next_rdat[N_CH-1:0] = stat;
        OFS_EN: next_rdat[N_CH-1:0] = en;
        default:
        begin
          if (ch_hit(i_wb_adr) && i_wb_adr[CH_CCR_BIT])
            next_rdat[15:0] = ccr[ch_idx(i_wb_adr)];
          else if (ch_hit(i_wb_adr))
            next_rdat[CFG_W-1:0] = cfg[ch_idx(i_wb_adr)];
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      mode <= TM_STOP;
      src <= 1'b0;
      div <= RST_DIV;
      en <= '0;
      for (int i = 0; i < int'(N_CH); i++)
      begin
        cfg[i] <= '0;
        ccr[i] <= RST_CCR;
      end
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      mode <= next_mode;
      src <= next_src;
      div <= next_div;
      en <= next_en;
      cfg <= next_cfg;
      ccr <= next_ccr;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter group: pin sync, prescaler, counter, direction
  tcp_dir_t dir, next_dir;
  logic [15:0] next_cnt;
  logic [2:0] sync, next_sync;
  logic [2:0] pre, next_pre;
  logic [2:0] pre_mask;
  logic base, tick;

  // sync[0] feeds only sync[1]; the edge is taken from the later stages
  assign base = src ? (sync[1] && !sync[2]) : 1'b1;
  assign pre_mask = 3'((4'h1 << div) - 4'h1);
  // at div 0 on the core source the counter steps every cycle
  assign tick = i_ce && mode != TM_STOP && base
    && (pre & pre_mask) == pre_mask;

  always_comb
  begin
    next_sync = {sync[1:0], i_count_pin};
    next_pre = base ? pre + 3'h1 : pre;
    next_cnt = cnt;
    next_dir = dir;
    if (mode != TM_UPDN || dir == ST_HALT)
      next_dir = (mode == TM_STOP) ? ST_HALT : ST_UP;
    if (cnt_clr)
    begin
      next_cnt = RST_CNT;
      next_pre = 3'h0;
    end
    else if (cnt_wr)
    begin
      next_cnt = merge16(cnt, i_wb_dat, i_wb_sel);
    end
    else if (tick)
    begin
      case (mode)
        TM_CONT: next_cnt = cnt + 16'h0001;
        TM_UP:
          // a period lowered below the count runs on to the wrap
          next_cnt = (cnt == ccr[0]) ? RST_CNT : cnt + 16'h0001;
        TM_UPDN:
        begin
          if (dir == ST_DOWN)
          begin
            if (cnt == RST_CNT)
            begin
              next_dir = ST_UP;
              next_cnt = (ccr[0] == RST_CNT) ? RST_CNT : cnt + 16'h0001;
            end
            else
              next_cnt = cnt - 16'h0001;
          end
          else if (cnt >= ccr[0])
          begin
            if (ccr[0] == RST_CNT)
              next_cnt = RST_CNT;
            else
            begin
              next_dir = ST_DOWN;
              next_cnt = cnt - 16'h0001;
            end
          end
          else
            next_cnt = cnt + 16'h0001;
        end
        default: next_cnt = cnt;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cnt <= RST_CNT;
      dir <= ST_HALT;
      sync <= 3'h0;
      pre <= 3'h0;
    end
    else if (i_ce)
    begin
      cnt <= next_cnt;
      dir <= next_dir;
      sync <= next_sync;
      pre <= next_pre;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, output units and interrupt status
  logic [N_CH-1:0] match;
  logic next_irq;
  logic period;

  // every channel, channel 0 included, compares in every mode except stop
  assign period = tick && cnt == ccr[0];

  genvar g;
  generate
    for (g = 0; g < int'(N_CH); g++)
    begin : g_ch
      assign match[g] = tick && cfg[g].cmp_en && cnt == ccr[g];

      tcp_channel u_ch (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_match(match[g]),
        .i_period(period),
        .i_cfg(cfg[g]),
        .o_out(o_pwm[g])
      );
    end
  endgenerate

  always_comb
  begin
    // a match in the clearing cycle survives the clear
    next_stat = (stat & ~clr_mask) | match;
    next_irq = |(next_stat & next_en);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      stat <= '0;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      stat <= next_stat;
      o_irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  cont_wrap_a: assert property (
    (tick && mode == TM_CONT && cnt == CNT_MAX && !cnt_wr && !cnt_clr)
      |=> cnt == RST_CNT)
    else $error("continuous count did not wrap to zero");

  cont_ch0_a: assert property (
    (tick && mode == TM_CONT && cnt == ccr[0] && cnt != CNT_MAX
      && !cnt_wr && !cnt_clr) |=> cnt == $past(cnt) + 16'h0001)
    else $error("channel 0 match disturbed continuous count");

  match_irq_a: assert property (
    (match[1] && next_en[1]) |=> stat[1] && o_irq)
    else $error("match did not raise status and interrupt");

  up_restart_a: assert property (
    (tick && mode == TM_UP && cnt == ccr[0] && !cnt_wr && !cnt_clr)
      |=> cnt == RST_CNT)
    else $error("up mode did not restart at period");

  updn_turn_a: assert property (
    (tick && mode == TM_UPDN && dir == ST_UP && cnt == ccr[0]
      && cnt != RST_CNT && !cnt_wr && !cnt_clr)
      |=> dir == ST_DOWN && cnt == $past(cnt) - 16'h0001)
    else $error("up-down did not turn at period");

  updn_down_a: assert property (
    (tick && mode == TM_UPDN && dir == ST_DOWN && cfg[2].cmp_en
      && cnt == ccr[2]) |=> stat[2])
    else $error("down-count match not flagged");

  full_rate_a: assert property (
    (i_ce && mode == TM_CONT && !src && div == 2'h0
      && !cnt_wr && !cnt_clr) |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter not stepping at core rate");

  reset_quiet_a: assert property (
    $past(i_rst) |-> cnt == RST_CNT && o_pwm == '0 && !o_irq
      && stat == '0)
    else $error("state not quiet after reset");

  bus_ack_a: assert property (
    (i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce) |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer not a single cycle");

endmodule : tcp_timer

`default_nettype wire

// file: hw/tcp_pkg.sv
package tcp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CFG_W = 5;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CLR = 8'h0C;
  localparam logic [7:0] OFS_EN = 8'h10;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam int unsigned CH_STEP_SH = 3;
  localparam int unsigned CH_CCR_BIT = 2;

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CLR_BIT = 2;
  localparam int unsigned CTRL_SRC_BIT = 3;
  localparam int unsigned CTRL_DIV_LSB = 4;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_CCR = 16'h0000;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    TM_STOP = 2'h0,
    TM_UP = 2'h1,
    TM_CONT = 2'h2,
    TM_UPDN = 2'h3
  } tcp_mode_t;

  typedef enum logic [2:0] {
    OM_BIT = 3'h0,
    OM_SET = 3'h1,
    OM_TGL_RST = 3'h2,
    OM_SET_RST = 3'h3,
    OM_TOGGLE = 3'h4,
    OM_RESET = 3'h5,
    OM_TGL_SET = 3'h6,
    OM_RST_SET = 3'h7
  } tcp_omode_t;

  // bit 4 compare enable, bit 3 output bit, bits 2:0 output mode
  typedef struct packed {
    logic cmp_en;
    logic out_bit;
    tcp_omode_t omode;
  } tcp_cfg_t;

  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_UP = 2'b01,
    ST_DOWN = 2'b11
  } tcp_dir_t;

endpackage : tcp_pkg

// file: hw/tcp_channel.sv
`timescale 1ns/100ps
`default_nettype none

module tcp_channel
  import tcp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_match,
  input wire logic i_period,
  input wire tcp_pkg::tcp_cfg_t i_cfg,
  output logic o_out
);

  logic out_q;
  logic next_out;

  assign o_out = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // output unit: match applies the first action, period the second
  always_comb
  begin
    next_out = out_q;
    if (!i_cfg.cmp_en || i_cfg.omode == OM_BIT)
    begin
      next_out = i_cfg.out_bit;
    end
    else if (i_match)
    begin
      case (i_cfg.omode)
        OM_SET: next_out = 1'b1;
        OM_TGL_RST: next_out = ~out_q;
        OM_SET_RST: next_out = 1'b1;
        OM_TOGGLE: next_out = ~out_q;
        OM_RESET: next_out = 1'b0;
        OM_TGL_SET: next_out = ~out_q;
        OM_RST_SET: next_out = 1'b0;
        default: next_out = out_q;
      endcase
    end
    else if (i_period)
    begin
      case (i_cfg.omode)
        OM_TGL_RST: next_out = 1'b0;
        OM_SET_RST: next_out = 1'b0;
        OM_TGL_SET: next_out = 1'b1;
        OM_RST_SET: next_out = 1'b1;
        default: next_out = out_q;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      out_q <= 1'b0;
    else if (i_ce)
      out_q <= next_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  set_mode_a: assert property (
    (i_ce && i_match && i_cfg.cmp_en && i_cfg.omode == OM_SET) |=> o_out)
    else $error("set mode did not drive output high");

  period_reset_a: assert property (
    (i_ce && i_period && !i_match && i_cfg.cmp_en
      && i_cfg.omode == OM_SET_RST) |=> !o_out)
    else $error("period event did not reset output");

endmodule : tcp_channel

`default_nettype wire

// file: dv/tcp_pwm_filter.sv
`timescale 1ns/100ps
`default_nettype none

module tcp_pwm_filter
  import tcp_pkg::*;
#(
  parameter int unsigned N = NUM_CH
)
(
  input wire logic i_core_clk,
  input wire logic i_run,
  input wire logic [N-1:0] i_pwm,
  output logic [N-1:0][15:0] o_hi,
  output logic [N-1:0][15:0] o_edges
);
  logic [N-1:0] last;

  // high time over the window stands for the filtered dac level
  always_ff @(posedge i_core_clk)
  begin
    last <= i_pwm;
    for (int n = 0; n < N; n++)
    begin
      o_hi[n] <= i_run ? o_hi[n] + 16'(i_pwm[n]) : 16'h0000;
      o_edges[n] <= i_run ? o_edges[n] + 16'(i_pwm[n] != last[n]) : 16'h0000;
    end
  end
endmodule : tcp_pwm_filter

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import tcp_pkg::*;
  logic clk, rst, cyc, stb, we, run, ack, irq, ce;
  logic [1:0] pc;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, r, rs;
  logic [NUM_CH-1:0] pwm;
  logic [NUM_CH-1:0][15:0] hi, edg, h, e;
  int fail_count, n_tests, cyc_n, c;

  tcp_timer #(.N_CH(NUM_CH)) DUT (.i_core_clk(clk), .i_rst(rst),
    .i_ce(ce), .i_count_pin(pc[1]), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .o_pwm(pwm));
  tcp_pwm_filter #(.N(NUM_CH)) filt (.i_core_clk(clk), .i_run(run),
    .i_pwm(pwm), .o_hi(hi), .o_edges(edg));

  //////////////////////////////////////////////////////////////////////////
  task stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task chk_rng(input logic [31:0] got, input int lo, input int up);
    n_tests++;
    if ((got >= lo && got <= up) !== 1'b1)
    begin
      fail_count++;
      $display("wrong value at %0t: %0h range %0h %0h", $time, got, lo, up);
    end
  endtask : chk_rng

  // no local limit: a hung wait is ended by the cycle watchdog
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task ccr(input int n, input int v);
    wb(1'b1, 8'(OFS_CH_BASE + (n << CH_STEP_SH) + 4), 32'(v));
  endtask : ccr

  task cctl(input int n, input logic [2:0] m, input logic ob, input logic en);
    wb(1'b1, 8'(OFS_CH_BASE + (n << CH_STEP_SH)), 32'({en, ob, m}));
  endtask : cctl

  task wait_irq();
    do
    begin
      @(posedge clk);
    end
    while (irq !== 1'b1);
  endtask : wait_irq

  task measure(input int w);
    @(posedge clk);
    run <= 1'b1;
    repeat (w) @(posedge clk);
    run <= 1'b0;
    @(posedge clk);
    h = hi;
    e = edg;
  endtask : measure

  // high cycles per period of ten, out bit set for mode 0
  function automatic int hi_up(input int m, input int cv);
    case (m)
      0, 1: return 10;
      2, 3: return 9 - cv;
      4: return 5;
      5: return 0;
      default: return cv + 1;
    endcase
  endfunction : hi_up

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    pc <= rst ? 2'h0 : pc + 2'h1;
    cyc_n++;
    if (cyc_n == 30000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    {rst, cyc, stb, we, run, ce} = 6'h21;
    adr = 8'h00;
    wdat = 32'h0;
    c = $urandom(32'hEFE4);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(pwm), 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b0, OFS_COUNT, 32'h0);
    chk(r, 32'h0);
    for (int n = 0; n < NUM_CH; n++)
    begin
      wb(1'b0, 8'(OFS_CH_BASE + (n << CH_STEP_SH) + 4), 32'h0);
      chk(r, 32'h0);
    end
    wb(1'b0, 8'h1C, 32'h0);
    chk(r, 32'h0);
    $display("reset test done");
    // wrap past the top value then match at zero
    wb(1'b1, OFS_EN, 32'h2);
    cctl(1, OM_SET, 1'b0, 1'b1);
    ccr(1, 0);
    wb(1'b1, OFS_COUNT, 32'hFFFE);
    wb(1'b1, OFS_CTRL, 32'h2);
    repeat (8) @(posedge clk);
    chk(32'(pwm[1]), 32'h1);
    chk(32'(irq), 32'h1);
    wb(1'b1, OFS_CTRL, 32'h0);
    wb(1'b1, OFS_STAT, 32'h0);
    wb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h2);
    wb(1'b1, OFS_EN, 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b1, OFS_CLR, 32'h2);
    wb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h0);
    $display("wrap test done");
    // continuous pwm, handler adds the next interval
    cctl(1, OM_BIT, 1'b0, 1'b0);
    cctl(0, OM_SET, 1'b0, 1'b1);
    ccr(0, 40);
    wb(1'b1, OFS_EN, 32'h1);
    wb(1'b1, OFS_CTRL, 32'h6);
    wait_irq();
    chk(32'(pwm[0]), 32'h1);
    ccr(0, 70);
    cctl(0, OM_RESET, 1'b0, 1'b1);
    wb(1'b1, OFS_CLR, 32'h1);
    wait_irq();
    chk(32'(pwm[0]), 32'h0);
    wb(1'b0, OFS_COUNT, 32'h0);
    chk_rng(r, 70, 90);
    $display("continuous test done");
    // up mode, every output mode on a shared period of ten
    wb(1'b1, OFS_CTRL, 32'h0);
    wb(1'b1, OFS_EN, 32'h0);
    cctl(0, OM_BIT, 1'b0, 1'b0);
    ccr(0, 9);
    wb(1'b1, OFS_CTRL, 32'h5);
    for (int m = 0; m < 8; m++)
    begin
      c = $urandom_range(8, 1);
      ccr(m % 4 + 1, c);
      cctl(m % 4 + 1, 3'(m), 1'b1, m != 0);
      repeat (20) @(posedge clk);
      measure(100);
      chk(32'(h[m % 4 + 1]), 32'(10 * hi_up(m, c)));
    end
    wb(1'b0, OFS_COUNT, 32'h0);
    chk_rng(r, 0, 9);
    $display("up mode test done");
    // up-down, two toggles per sixteen-cycle turn
    wb(1'b1, OFS_CTRL, 32'h0);
    ccr(0, 8);
    for (int n = 1; n < NUM_CH; n++)
    begin
      ccr(n, $urandom_range(7, 1));
      cctl(n, OM_TOGGLE, 1'b0, 1'b1);
    end
    wb(1'b1, OFS_CTRL, 32'h7);
    repeat (20) @(posedge clk);
    measure(160);
    for (int n = 1; n < NUM_CH; n++)
      chk(32'(e[n]), 32'h14);
    wb(1'b0, OFS_COUNT, 32'h0);
    chk_rng(r, 0, 8);
    $display("up-down test done");
    // pin source, divide by four, then full core rate
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b1, OFS_CTRL, (k == 0) ? 32'hE : (k == 1) ? 32'h26 : 32'h6);
      repeat (40) @(posedge clk);
      wb(1'b0, OFS_COUNT, 32'h0);
      chk_rng(r, (k == 2) ? 38 : 8, (k == 2) ? 46 : 12);
    end
    $display("clock source test done");
    // enable low for twenty edges: only four count steps around it
    wb(1'b0, OFS_COUNT, 32'h0);
    rs = r;
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wb(1'b0, OFS_COUNT, 32'h0);
    chk(r, rs + 32'h4);
    $display("clock enable test done");
    stop_test();
  end
endmodule : tb

`default_nettype wire
